// ===== dos_top.v
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`include "dos_map.vh"
module dos_top (
  input wire aclk,
  input wire aresetn,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire hydraulic_option_one,
  input wire hydraulic_option_two,
  input wire cylinder_extend_drive,
  input wire cylinder_retract_drive,
  input wire valve_bypass_drive,
  input wire valve_direction_switch,
  input wire fast_discharge_active,
  input wire chopper_overload_warning,
  input wire fault_reaction_active,
  input wire error_active,
  input wire [6:0] digital_input,
  input wire analogue_input_0,
  input wire analogue_input_1,
  input wire safe_torque_off,
  input wire position_limited,
  input wire signed [31:0] torque_reference,
  input wire signed [31:0] torque_actual,
  input wire signed [31:0] speed_reference,
  input wire signed [31:0] speed_actual,
  input wire signed [31:0] position_reference,
  input wire signed [31:0] position_actual,
  output reg relay_output_one,
  output reg relay_output_two,
  output reg [3:0] switching_output,
  output reg irq
);
  // ************************************
  // Register state
  // ************************************
  reg [7:0] rel1_sel_reg;
  reg [31:0] invert_reg;
  reg [31:0] window_reg;
  reg [31:0] tmax_reg;
  reg [31:0] nmax_reg;
  reg [1:0] mode_reg;
  reg [3:0] irq_stat_reg;
  reg [3:0] irq_mask_reg;
  reg [31:0] state_reg;
  reg aw_hold_reg;
  reg w_hold_reg;
  reg [7:0] awaddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  reg rd_pend_reg;
  reg [7:0] araddr_reg;
  wire [31:0] sel_all;
  wire [7:0] sel_rdata;
  wire [7:0] sw_sel [0:3];

  // ************************************
  // Write channel
  // ************************************
  wire wr_go = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
  // Selector store only takes aligned words, like every other register
  wire wr_sel = wr_go && awaddr_reg[7:4] == 4'h1 && awaddr_reg[1:0] == 2'h0 && wstrb_reg[0];

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else begin
      s_axi_awready <= !aw_hold_reg && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_hold_reg && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_reg > `DOS_OFF_IRQ_MASK || awaddr_reg[1:0] != 2'h0) ? 2'h2 : 2'h0;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (strb[i])
          merge[8*i +: 8] = nw[8*i +: 8];
    end
  endfunction

  // ************************************
  // Function selection
  // ************************************
  function is_defined;
    input [7:0] code;
    begin
      is_defined = code == `DOS_CODE_REF || code == `DOS_CODE_LIMIT || code == `DOS_CODE_STO ||
                   (code >= `DOS_CODE_HYD1 && code <= `DOS_CODE_AIN1);
    end
  endfunction

  reg ref_reached;
  reg limit_hit;
  reg [3:0] ev_now;
  reg [3:0] ev_prev_reg;
  reg [21:0] route_src;

  function route;
    input [7:0] code;
    input [21:0] src;
    reg [7:0] src_idx;
    begin
      src_idx = code - `DOS_CODE_HYD1;
      case (code)
        `DOS_CODE_REF: route = src[19];
        `DOS_CODE_LIMIT: route = src[20];
        `DOS_CODE_STO: route = src[21];
        `DOS_CODE_HYD1: route = src[0];
        `DOS_CODE_HYD2: route = src[1];
        `DOS_CODE_CYL_EXT: route = src[2];
        `DOS_CODE_CYL_RET: route = src[3];
        `DOS_CODE_BYPASS: route = src[4];
        `DOS_CODE_DIRSW: route = src[5];
        `DOS_CODE_DISCH: route = src[6];
        `DOS_CODE_WBRK: route = src[7];
        `DOS_CODE_FREACT: route = src[8];
        `DOS_CODE_ERR: route = src[9];
        `DOS_CODE_AIN0: route = src[17];
        `DOS_CODE_AIN1: route = src[18];
        default: begin
          // Only the digital input codes are still defined here
          if (is_defined(code))
            route = src[src_idx[4:0]];
          else
            route = 1'b0;
        end
      endcase
    end
  endfunction

  function [31:0] absdiff;
    input signed [31:0] a;
    input signed [31:0] b;
    reg signed [32:0] d;
    reg signed [32:0] nd;
    begin
      d = {a[31], a} - {b[31], b};
      nd = -d;
      absdiff = d[32] ? nd[31:0] : d[31:0];
    end
  endfunction

  function signed [31:0] absval;
    input signed [31:0] a;
    begin
      absval = a[31] ? -a : a;
    end
  endfunction

  always @* begin
    case (mode_reg)
      `DOS_MODE_TORQUE: ref_reached = absdiff(torque_reference, torque_actual) <= window_reg;
      `DOS_MODE_SPEED: ref_reached = absdiff(speed_reference, speed_actual) <= window_reg;
      `DOS_MODE_POS: ref_reached = absdiff(position_reference, position_actual) <= window_reg;
      default: ref_reached = 1'b0;
    endcase
    // Positioning watches both speed and torque limits
    case (mode_reg)
      `DOS_MODE_TORQUE: limit_hit = $unsigned(absval(torque_reference)) > tmax_reg;
      `DOS_MODE_SPEED: limit_hit = $unsigned(absval(speed_reference)) > nmax_reg;
      `DOS_MODE_POS: limit_hit = position_limited || $unsigned(absval(speed_reference)) > nmax_reg ||
                                 $unsigned(absval(torque_reference)) > tmax_reg;
      default: limit_hit = 1'b0;
    endcase
    ev_now = {error_active, fault_reaction_active, chopper_overload_warning, safe_torque_off};
    // Sources go in as one vector so that @* sees every one of them
    route_src = {safe_torque_off, limit_hit, ref_reached, analogue_input_1, analogue_input_0, digital_input,
                 error_active, fault_reaction_active, chopper_overload_warning, fast_discharge_active,
                 valve_direction_switch, valve_bypass_drive, cylinder_retract_drive, cylinder_extend_drive,
                 hydraulic_option_two, hydraulic_option_one};
  end

  // ************************************
  // Output stage
  // ************************************
  reg [31:0] state_next;
  integer k;
  always @* begin
    state_next = 32'h0000_0000;
    for (k = 0; k < 4; k = k + 1)
      state_next[k] = route(sel_all[8*k +: 8], route_src) ^ invert_reg[k];
    state_next[`DOS_BIT_REL1] = route(rel1_sel_reg, route_src) ^ invert_reg[`DOS_BIT_REL1];
    state_next[`DOS_BIT_REL2] = safe_torque_off ^ invert_reg[`DOS_BIT_REL2];
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= 32'h0000_0000;
      relay_output_one <= 1'b0;
      relay_output_two <= 1'b0;
      switching_output <= 4'h0;
      ev_prev_reg <= 4'h0;
      irq <= 1'b0;
    end else begin
      state_reg <= state_next;
      relay_output_one <= state_next[`DOS_BIT_REL1];
      relay_output_two <= state_next[`DOS_BIT_REL2];
      switching_output <= state_next[3:0];
      ev_prev_reg <= ev_now;
      // A set mask bit lets its event through
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // ************************************
  // Software registers
  // ************************************
  wire wr_ok = wr_go && awaddr_reg[1:0] == 2'h0;
  wire [3:0] ev_rise = ev_now & ~ev_prev_reg;
  wire [3:0] irq_clr = (wr_ok && awaddr_reg == `DOS_OFF_IRQ_STAT && wstrb_reg[0]) ? wdata_reg[3:0] : 4'h0;

  always @(posedge aclk) begin
    if (!aresetn) begin
      rel1_sel_reg <= `DOS_RST_SEL;
      invert_reg <= `DOS_RST_INVERT;
      window_reg <= `DOS_RST_WINDOW;
      tmax_reg <= `DOS_RST_LIMIT;
      nmax_reg <= `DOS_RST_LIMIT;
      mode_reg <= `DOS_MODE_SPEED;
      irq_stat_reg <= `DOS_RST_IRQ;
      irq_mask_reg <= `DOS_RST_IRQ;
    end else begin
      // New event wins over a clear in the same cycle
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | ev_rise;
      if (wr_ok) begin
        case (awaddr_reg)
          `DOS_OFF_REL1_SEL: if (wstrb_reg[0]) rel1_sel_reg <= wdata_reg[7:0];
          `DOS_OFF_INVERT: invert_reg <= merge(invert_reg, wdata_reg, wstrb_reg);
          `DOS_OFF_WINDOW: window_reg <= merge(window_reg, wdata_reg, wstrb_reg);
          `DOS_OFF_TMAX: tmax_reg <= merge(tmax_reg, wdata_reg, wstrb_reg);
          `DOS_OFF_NMAX: nmax_reg <= merge(nmax_reg, wdata_reg, wstrb_reg);
          `DOS_OFF_MODE: if (wstrb_reg[0]) mode_reg <= wdata_reg[1:0];
          `DOS_OFF_IRQ_MASK: if (wstrb_reg[0]) irq_mask_reg <= wdata_reg[3:0];
          default: ;
        endcase
      end
    end
  end

  dos_sel_mem #(
    .N(4)
  ) u_sel (
    .aclk(aclk),
    .aresetn(aresetn),
    .we(wr_sel),
    .waddr(awaddr_reg[3:2]),
    .wdata(wdata_reg[7:0]),
    .raddr(s_axi_araddr[3:2]),
    .rdata(sel_rdata),
    .all_sel(sel_all)
  );

  // ************************************
  // Read channel
  // ************************************
  // Two-cycle read lets the selector store answer from its register
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
      rd_pend_reg <= 1'b0;
      araddr_reg <= 8'h00;
    end else begin
      s_axi_arready <= !s_axi_arready && !rd_pend_reg && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        rd_pend_reg <= 1'b1;
        araddr_reg <= s_axi_araddr[7:0];
      end
      if (rd_pend_reg) begin
        rd_pend_reg <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        case (araddr_reg)
          `DOS_OFF_REL1_SEL: s_axi_rdata <= {24'h000000, rel1_sel_reg};
          `DOS_OFF_REL2_SEL: s_axi_rdata <= {24'h000000, `DOS_CODE_STO};
          `DOS_OFF_INVERT: s_axi_rdata <= invert_reg;
          `DOS_OFF_STATE: s_axi_rdata <= state_reg;
          `DOS_OFF_SEL_BASE, `DOS_OFF_SEL1, `DOS_OFF_SEL2, `DOS_OFF_SEL3: s_axi_rdata <= {24'h000000, sel_rdata};
          `DOS_OFF_WINDOW: s_axi_rdata <= window_reg;
          `DOS_OFF_TMAX: s_axi_rdata <= tmax_reg;
          `DOS_OFF_NMAX: s_axi_rdata <= nmax_reg;
          `DOS_OFF_MODE: s_axi_rdata <= {30'h0, mode_reg};
          `DOS_OFF_IRQ_STAT: s_axi_rdata <= {28'h0000000, irq_stat_reg};
          `DOS_OFF_IRQ_MASK: s_axi_rdata <= {28'h0000000, irq_mask_reg};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// ===== dos_map.vh
`ifndef DOS_MAP_VH
`define DOS_MAP_VH
`define DOS_OFF_REL1_SEL 8'h00
`define DOS_OFF_REL2_SEL 8'h04
`define DOS_OFF_INVERT 8'h08
`define DOS_OFF_STATE 8'h0c
`define DOS_OFF_SEL_BASE 8'h10
`define DOS_OFF_SEL1 8'h14
`define DOS_OFF_SEL2 8'h18
`define DOS_OFF_SEL3 8'h1c
`define DOS_OFF_WINDOW 8'h20
`define DOS_OFF_TMAX 8'h24
`define DOS_OFF_NMAX 8'h28
`define DOS_OFF_MODE 8'h2c
`define DOS_OFF_IRQ_STAT 8'h30
`define DOS_OFF_IRQ_MASK 8'h34
`define DOS_CODE_REF 8'h06
`define DOS_CODE_LIMIT 8'h0e
`define DOS_CODE_STO 8'h37
`define DOS_CODE_HYD1 8'h4a
`define DOS_CODE_HYD2 8'h4b
`define DOS_CODE_CYL_EXT 8'h4c
`define DOS_CODE_CYL_RET 8'h4d
`define DOS_CODE_BYPASS 8'h4e
`define DOS_CODE_DIRSW 8'h4f
`define DOS_CODE_DISCH 8'h50
`define DOS_CODE_WBRK 8'h51
`define DOS_CODE_FREACT 8'h52
`define DOS_CODE_ERR 8'h53
`define DOS_CODE_DIN0 8'h54
`define DOS_CODE_DIN6 8'h5a
`define DOS_CODE_AIN0 8'h5b
`define DOS_CODE_AIN1 8'h5c
`define DOS_BIT_REL1 8
`define DOS_BIT_REL2 15
`define DOS_MODE_TORQUE 2'h0
`define DOS_MODE_SPEED 2'h1
`define DOS_MODE_POS 2'h2
`define DOS_RST_SEL 8'h00
`define DOS_RST_INVERT 32'h0000_0000
`define DOS_RST_WINDOW 32'h0000_0000
`define DOS_RST_LIMIT 32'h7fff_ffff
`define DOS_RST_IRQ 4'h0
`endif

// ===== dos_sel_mem.v
`timescale 1ns/1ps
// ************************************
// Selector store, registered read
// ************************************
module dos_sel_mem #(
  parameter N = 4
) (
  input wire aclk,
  input wire aresetn,
  input wire we,
  input wire [1:0] waddr,
  input wire [7:0] wdata,
  input wire [1:0] raddr,
  output reg [7:0] rdata,
  output wire [8*N-1:0] all_sel
);
  reg [7:0] mem_reg [0:N-1];
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : g_sel
      always @(posedge aclk) begin
        if (!aresetn)
          mem_reg[g] <= 8'h00;
        else if (we && waddr == g)
          mem_reg[g] <= wdata;
      end
      assign all_sel[8*g +: 8] = mem_reg[g];
    end
  endgenerate
  always @(posedge aclk) begin
    if (!aresetn)
      rdata <= 8'h00;
    else
      rdata <= mem_reg[raddr];
  end
endmodule

// ===== dos_load_model.sv
`timescale 1ns/1ps
// ************************************
// Relay coils and switching loads
// ************************************
module dos_load_model (
  input wire aclk,
  input wire relay_output_one,
  input wire relay_output_two,
  input wire [3:0] switching_output,
  output reg [5:0] coil
);
  // Coils pull in one clock late; contact bounce not modelled
  always @(posedge aclk) begin
    coil <= {relay_output_two, relay_output_one, switching_output};
  end
endmodule

// ===== dos_checker.sv
`timescale 1ns/1ps
module dos_checker (
  input wire aclk,
  input wire aresetn,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire safe_torque_off,
  input wire relay_output_one,
  input wire relay_output_two,
  input wire [3:0] switching_output,
  input wire irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Writes and reset may legally move relay two through its inversion bit
  logic [2:0] since_wr;
  always @(posedge aclk) begin
    if (!aresetn || s_axi_wvalid || s_axi_bvalid) begin
      since_wr <= 3'h4;
    end else if (since_wr != 3'h0) begin
      since_wr <= since_wr - 3'h1;
    end
  end
  chk_reset_quiet: assert property (disable iff (1'b0) !aresetn |=>
    !relay_output_one && !relay_output_two && switching_output == 4'h0 && !irq)
    else $error("outputs active after reset");
  chk_read_latency: assert property (s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
    else $error("read answer late");
  chk_rel2_code: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:0] == 8'h04
    |-> ##2 s_axi_rdata == 32'h37 && s_axi_rresp == 2'h0)
    else $error("relay two selector not fixed");
  chk_unmapped_err: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:0] == 8'hfc
    |-> ##2 s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  chk_write_answer: assert property (s_axi_wvalid && s_axi_wready |-> ##[1:4] s_axi_bvalid)
    else $error("write answer missing");
  chk_bresp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  chk_rresp_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  chk_relay2_cause: assert property ($changed(relay_output_two) |->
    $past(safe_torque_off) != $past(safe_torque_off, 2) || since_wr != 3'h0)
    else $error("relay two moved without cause");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property ($rose(irq));
  cover property ($rose(relay_output_two));
endmodule
bind dos_top dos_checker i_chk (.aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .safe_torque_off, .relay_output_one, .relay_output_two, .switching_output, .irq);

// ===== test_dos_top.sv
`timescale 1ns/1ps
module test_dos_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0, safe_torque_off = 1'b0, position_limited = 1'b0;
  wire [3:0] s_axi_wstrb = 4'hf;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  logic [18:0] src = 19'h0;
  logic signed [31:0] torque_reference = 32'sh0, speed_reference = 32'sh0, speed_actual = 32'sh0;
  wire signed [31:0] torque_actual = 32'sh0, position_reference = 32'sh0, position_actual = 32'sh0;
  wire hydraulic_option_one = src[0], hydraulic_option_two = src[1], cylinder_extend_drive = src[2],
    cylinder_retract_drive = src[3], valve_bypass_drive = src[4], valve_direction_switch = src[5],
    fast_discharge_active = src[6], chopper_overload_warning = src[7], fault_reaction_active = src[8],
    error_active = src[9], analogue_input_0 = src[17], analogue_input_1 = src[18];
  wire [6:0] digital_input = src[16:10];
  wire relay_output_one, relay_output_two, irq;
  wire [3:0] switching_output;
  wire [5:0] coil;
  int fails = 0, checks_done = 0;
  logic [31:0] rd;
  logic [1:0] rr;
  int undef[3] = '{32'h47, 32'h49, 32'h5d};
  dos_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .hydraulic_option_one,
    .hydraulic_option_two, .cylinder_extend_drive, .cylinder_retract_drive, .valve_bypass_drive,
    .valve_direction_switch, .fast_discharge_active, .chopper_overload_warning, .fault_reaction_active,
    .error_active, .digital_input, .analogue_input_0, .analogue_input_1, .safe_torque_off, .position_limited,
    .torque_reference, .torque_actual, .speed_reference, .speed_actual, .position_reference, .position_actual,
    .relay_output_one, .relay_output_two, .switching_output, .irq);
  dos_load_model i_load (.aclk, .relay_output_one, .relay_output_two, .switching_output, .coil);
  always #5 aclk = ~aclk;
  // ************************************
  // Bus and compare tasks
  // ************************************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Trailing edge keeps back-to-back calls from driving a strobe twice at once
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd_reg(input logic [7:0] a);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    rd_reg(a);
    check(name, rd, exp);
  endtask
  task automatic finish_test;
    if (fails == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ************************************
  // Tests
  // ************************************
  initial begin
    repeat (5000) @(posedge aclk);
    fails++;
    finish_test;
  end
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rchk("rel2_sel", 8'h04, 32'h37);
    rchk("rel1_sel", 8'h00, 32'h0);
    rchk("invert", 8'h08, 32'h0);
    wr(8'h04, 32'h0);
    rchk("rel2_fixed", 8'h04, 32'h37);
    rd_reg(8'hfc);
    check("unmapped_resp", rr, 2'h2);
    check("unmapped_data", rd, 32'h0);
    for (int i = 0; i < 19; i++) begin
      wr(8'h00, 32'h4a + i);
      wr(8'h10, 32'h4a + i);
      src <= 19'h1 << i;
      tick(3);
      check("code_on", {relay_output_one, switching_output[0]}, 2'h3);
      src <= ~(19'h1 << i);
      tick(3);
      check("code_off", {relay_output_one, switching_output[0]}, 2'h0);
    end
    foreach (undef[k]) begin
      wr(8'h00, undef[k]);
      tick(3);
      check("undefined", relay_output_one, 1'b0);
    end
    src <= 19'h0;
    wr(8'h00, 32'h53);
    wr(8'h10, 32'h53);
    wr(8'h08, 32'h8101);
    tick(3);
    check("inverted", {relay_output_two, relay_output_one, switching_output}, 6'h31);
    rchk("state", 8'h0c, 32'h8101);
    check("load", coil, 6'h31);
    src <= 19'h200;
    tick(3);
    check("inv_active", relay_output_one, 1'b0);
    wr(8'h08, 32'h0);
    wr(8'h14, 32'h37);
    safe_torque_off <= 1'b1;
    tick(3);
    check("sto_on", {relay_output_two, switching_output[1]}, 2'h3);
    safe_torque_off <= 1'b0;
    tick(3);
    check("sto_off", {relay_output_two, switching_output[1]}, 2'h0);
    wr(8'h18, 32'he);
    wr(8'h28, 32'h64);
    speed_reference <= 32'sh64;
    tick(3);
    check("lim_speed_eq", switching_output[2], 1'b0);
    speed_reference <= -32'sh65;
    tick(3);
    check("lim_speed", switching_output[2], 1'b1);
    speed_reference <= 32'sh0;
    wr(8'h2c, 32'h0);
    wr(8'h24, 32'h32);
    torque_reference <= 32'sh33;
    tick(3);
    check("lim_torque", switching_output[2], 1'b1);
    torque_reference <= 32'sh32;
    tick(3);
    check("lim_torque_eq", switching_output[2], 1'b0);
    wr(8'h2c, 32'h1);
    wr(8'h1c, 32'h6);
    wr(8'h20, 32'h5);
    speed_actual <= 32'sh3;
    speed_reference <= 32'sh8;
    tick(3);
    check("ref_edge", switching_output[3], 1'b1);
    speed_reference <= 32'sh9;
    tick(3);
    check("ref_out", switching_output[3], 1'b0);
    speed_reference <= -32'sh2;
    tick(3);
    check("ref_neg", switching_output[3], 1'b1);
    wr(8'h2c, 32'h2);
    speed_reference <= 32'sh20;
    position_limited <= 1'b1;
    tick(3);
    check("pos_mode", switching_output[3:2], 2'h3);
    position_limited <= 1'b0;
    tick(3);
    check("pos_lim_off", switching_output[2], 1'b0);
    rchk("irq_status", 8'h30, 32'hf);
    wr(8'h34, 32'hf);
    tick(2);
    check("irq_on", irq, 1'b1);
    wr(8'h34, 32'h0);
    tick(2);
    check("irq_masked", irq, 1'b0);
    wr(8'h30, 32'hf);
    rchk("irq_clear", 8'h30, 32'h0);
    wr(8'h34, 32'hf);
    tick(2);
    check("irq_idle", irq, 1'b0);
    safe_torque_off <= 1'b1;
    wr(8'h00, 32'h37);
    tick(2);
    check("pre_reset", {relay_output_two, relay_output_one, irq}, 3'h7);
    aresetn <= 1'b0;
    tick(2);
    check("in_reset", {relay_output_two, relay_output_one, switching_output, irq}, 7'h0);
    aresetn <= 1'b1;
    tick(2);
    check("after_reset", {relay_output_two, relay_output_one}, 2'h2);
    rchk("rst_rel1_sel", 8'h00, 32'h0);
    rchk("rst_mode", 8'h2c, 32'h1);
    finish_test;
  end
endmodule
